// *** orient_pkg.sv ***
// Constants and types for the orientation status and configuration block.
// Assumes a register port driven by the device's serial interface logic.
package orient_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_ORIENTATION_STATUS = 8'h10;
    localparam logic [7:0] ADDR_ORIENTATION_CONFIG = 8'h11;
    localparam int STAT_FLAG_BIT = 7;
    localparam int STAT_LOCK_BIT = 6;
    localparam int STAT_ORIENT_LSB = 1;
    localparam int STAT_FACING_BIT = 0;
    localparam int CFG_MODE_BIT = 7;
    localparam int CFG_EN_BIT = 6;
    localparam logic CFG_MODE_RESET = 1'b1;
    localparam logic CFG_EN_RESET = 1'b0;
    // Orientation field encoding
    typedef enum logic [1:0] {
        PORTRAIT_UP = 2'b00,
        PORTRAIT_DOWN = 2'b01,
        LANDSCAPE_RIGHT = 2'b10,
        LANDSCAPE_LEFT = 2'b11
    } orient_t;
    // Debounce counter width and axis sample width
    localparam int DBNC_W = 8;
    localparam int AXIS_W = 12;
    // 1.25 g at 1024 counts per g (2 g full scale, 12-bit)
    localparam logic [AXIS_W-1:0] LIMIT_1G25 = 12'h500;
endpackage

// *** orient_debounce.sv ***
// Debounce counter for orientation candidate changes.
// Assumes one-cycle sample strobes on the same clock.
`timescale 1ns/1ns
module orient_debounce
    import orient_pkg::*;
#(
    parameter int W = DBNC_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic sample,
    input wire logic restart,
    input wire logic pending,
    input wire logic clear_mode,
    input wire logic [W-1:0] limit,
    // Result
    output logic done
);
    logic [W-1:0] count;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // Counts pending samples; lapse behaviour selected by mode
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            count <= '0;
        end else if (sample) begin
            if (pending) begin
                if (count != limit) begin
                    count <= W'(count + 1'b1);
                end
            end else if (clear_mode) begin
                count <= '0;
            end else if (count != '0) begin
                count <= W'(count - 1'b1);
            end
        end
    end

    // Done once the pending condition has lasted the full count
    assign done = sample && pending && (count >= limit);
endmodule

// *** orientation_status_config.sv ***
// Orientation status and configuration registers with detection logic.
// Holds the status and configuration bytes, the candidate decision and the change flag.
// Assumes axis samples, strobes and mode levels come from on-chip logic on ref_clk.
// Assumes axis samples are two's complement at 1024 counts per g; other scales need a new limit.
// Assumes the serial interface pulses each register strobe for exactly one cycle.
`timescale 1ns/1ns
module orientation_status_config
    import orient_pkg::*;
#(
    parameter int AW = AXIS_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sample stream and system state
    input wire logic sample_strobe,
    input wire logic active_mode,
    input wire logic sleep_mode,
    input wire logic [AW-1:0] accel_x,
    input wire logic [AW-1:0] accel_y,
    input wire logic [AW-1:0] accel_z,
    input wire logic ztilt_trip,
    input wire logic [DBNC_W-1:0] debounce_count,
    // Interrupt path
    input wire logic orient_irq_enable,
    output logic orient_irq_source
);
    logic orient_change_flag;
    logic ztilt_lockout;
    orient_t orient_field;
    logic facing_bit;
    logic debounce_mode;
    logic orient_detect_enable;
    logic was_active;
    logic first_pending;
    logic last_sleep;
    logic eval;
    logic over_limit;
    logic pending;
    logic done;
    logic status_read;
    orient_t cand_orient;
    logic cand_facing;
    logic next_change;
    logic sleep_edge;
    logic config_write;
    logic [AW-1:0] axis_raw [3];
    logic [AW-1:0] axis_mag [3];
    logic [2:0] axis_over;

    // Absolute value of a signed axis sample
    function automatic logic [AW-1:0] mag(input logic [AW-1:0] v);
        mag = v[AW-1] ? AW'(~v + 1'b1) : v;
    endfunction

    // Register strobe aimed at one address; shared by the read and write decodes
    function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction

    // Status byte layout; bits 5:3 stay zero
    function automatic logic [7:0] pack_status(input logic flag, input logic lock, input orient_t orient,
        input logic facing);
        pack_status = 8'h00;
        pack_status[STAT_FLAG_BIT] = flag;
        pack_status[STAT_LOCK_BIT] = lock;
        pack_status[STAT_ORIENT_LSB +: 2] = orient;
        pack_status[STAT_FACING_BIT] = facing;
    endfunction

    // ----------------------------------------
    // Axis magnitudes
    // ----------------------------------------
    // Axes as an indexed set: 0 is X, 1 is Y, 2 is Z
    assign axis_raw[0] = accel_x;
    assign axis_raw[1] = accel_y;
    assign axis_raw[2] = accel_z;

    // One magnitude and one strict 1.25 g compare per axis
    // The most negative code negates to itself and still counts as over the limit
    generate
        for (genvar i = 0; i < 3; i++) begin : g_axis
            assign axis_mag[i] = mag(axis_raw[i]);
            assign axis_over[i] = axis_mag[i] > LIMIT_1G25;
        end
    endgenerate

    // ----------------------------------------
    // Candidate orientation
    // ----------------------------------------
    // Dominant horizontal axis picks portrait or landscape; Z sign picks facing
    always_comb begin
        if (axis_mag[1] >= axis_mag[0]) begin
            cand_orient = accel_y[AW-1] ? PORTRAIT_DOWN : PORTRAIT_UP;
        end else begin
            cand_orient = accel_x[AW-1] ? LANDSCAPE_LEFT : LANDSCAPE_RIGHT;
        end
        cand_facing = accel_z[AW-1];
    end

    // Any axis beyond 1.25 g freezes the result
    assign over_limit = |axis_over;
    assign eval = sample_strobe && active_mode && orient_detect_enable && !over_limit;
    assign pending = (cand_orient != orient_field) || (cand_facing != facing_bit)
        || (ztilt_trip != ztilt_lockout);
    assign status_read = hit(reg_rd, reg_addr, ADDR_ORIENTATION_STATUS);
    assign config_write = hit(reg_wr, reg_addr, ADDR_ORIENTATION_CONFIG);
    // Either direction of a wake/sleep change restarts the debounce count
    assign sleep_edge = sleep_mode != last_sleep;

    // ----------------------------------------
    // Debounce
    // ----------------------------------------
    // The count rests at its limit after a change; the next matching sample lapses it
    orient_debounce #(
        .W(DBNC_W)
    ) u_debounce (
        .ref_clk(ref_clk),
        .rst(rst),
        .sample(eval),
        .restart(sleep_edge),
        .pending(pending),
        .clear_mode(debounce_mode),
        .limit(debounce_count),
        .done(done)
    );

    // Mode tracking for wake/sleep edges and standby-to-active entry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_sleep <= 1'b0;
            was_active <= 1'b0;
        end else begin
            last_sleep <= sleep_mode;
            was_active <= active_mode;
        end
    end

    // First evaluated sample after activation raises the flag even with no change
    // Entry wins over a same-cycle sample, so that sample leaves the request armed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            first_pending <= 1'b0;
        end else if (active_mode && !was_active) begin
            first_pending <= 1'b1;
        end else if (eval) begin
            first_pending <= 1'b0;
        end
    end

    // ----------------------------------------
    // Result fields
    // ----------------------------------------
    // Fields update regardless of the change flag state
    // Over 1.25 g no sample is evaluated, so the held result needs no extra gate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            orient_field <= PORTRAIT_UP;
            facing_bit <= 1'b0;
            ztilt_lockout <= 1'b0;
        end else if (done) begin
            orient_field <= cand_orient;
            facing_bit <= cand_facing;
            ztilt_lockout <= ztilt_trip;
        end
    end

    // Change flag: a new event in the read cycle wins over the clear
    // The interrupt source follows this flag and falls on the same edge
    assign next_change = done || (eval && first_pending);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            orient_change_flag <= 1'b0;
        end else if (next_change) begin
            orient_change_flag <= 1'b1;
        end else if (status_read) begin
            orient_change_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    // Host writes land on the edge that takes the strobe
    // Writes to the status address fall through and are ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            debounce_mode <= CFG_MODE_RESET;
            orient_detect_enable <= CFG_EN_RESET;
        end else if (config_write) begin
            debounce_mode <= reg_wdata[CFG_MODE_BIT];
            orient_detect_enable <= reg_wdata[CFG_EN_BIT];
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Registered so the data output comes from flip-flops
    // Unmapped addresses read as zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= 8'h00;
            if (reg_addr == ADDR_ORIENTATION_STATUS) begin
                reg_rdata <= pack_status(orient_change_flag, ztilt_lockout, orient_field, facing_bit);
            end else if (reg_addr == ADDR_ORIENTATION_CONFIG) begin
                reg_rdata[CFG_MODE_BIT] <= debounce_mode;
                reg_rdata[CFG_EN_BIT] <= orient_detect_enable;
            end
        end
    end

    // Source bit follows the flag, so a status read drops it
    assign orient_irq_source = orient_change_flag && orient_irq_enable;
endmodule

// *** orient_chk.sv ***
// Checker for the orientation status block, bound to its top module.
// Assumes single-cycle register strobes on ref_clk.
`timescale 1ns/1ns
module orient_chk
    import orient_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    // Sample and interrupt
    input wire logic sample_strobe,
    input wire logic orient_irq_enable,
    input wire logic orient_irq_source
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // A sample in the read cycle may set the flag again, so clean reads exclude it
    wire st_any = reg_rd && reg_addr == ADDR_ORIENTATION_STATUS;
    wire st_rd = st_any && !sample_strobe;
    property p_rst; disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !orient_irq_source; endproperty
    a_rst: assert property (p_rst) else $error("bad reset value");
    property p_ack; st_rd |=> !orient_irq_source; endproperty
    a_ack: assert property (p_ack) else $error("irq kept after read");
    property p_clr; st_rd ##1 !sample_strobe ##1 st_rd |=> !reg_rdata[7]; endproperty
    a_clr: assert property (p_clr) else $error("flag kept after read");
    property p_pad; st_any |=> reg_rdata[5:3] == 3'b000; endproperty
    a_pad: assert property (p_pad) else $error("status pad bits set");
    property p_cfg; reg_rd && reg_addr == ADDR_ORIENTATION_CONFIG |=> reg_rdata[5:0] == 6'h00; endproperty
    a_cfg: assert property (p_cfg) else $error("config pad bits set");
    property p_msk; !orient_irq_enable |-> !orient_irq_source; endproperty
    a_msk: assert property (p_msk) else $error("masked irq seen");
    property p_src; $rose(orient_irq_source) && $stable(orient_irq_enable) |-> $past(sample_strobe, 2) || $past(sample_strobe); endproperty
    a_src: assert property (p_src) else $error("irq without sample");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // Main scenarios
    c_flag: cover property (st_any ##1 reg_rdata[7]);
    c_irq: cover property ($rose(orient_irq_source));
    c_dis: cover property (reg_rd && reg_addr == ADDR_ORIENTATION_CONFIG ##1 !reg_rdata[6]);
endmodule
bind orientation_status_config orient_chk i_chk (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
    .orient_irq_enable(orient_irq_enable), .orient_irq_source(orient_irq_source));

// *** orient_host.sv ***
// Host register master for the orientation block.
// Assumes requests launch 1 ns after the rising edge of ref_clk.
`timescale 1ns/1ns
module orient_host (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle lines carry flipped values so a stale address never looks live
    initial begin
        {reg_rd, reg_wr, reg_addr, reg_wdata} = 18'h05aa5;
    end
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge ref_clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    // One-cycle read strobe; data is taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge ref_clk);
        #1 {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the orientation status block.
// Assumes the host model issues all register traffic.
`timescale 1ns/1ns
module tb;
    import orient_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_rd, reg_wr, sample_strobe, active_mode, sleep_mode, ztilt_trip, orient_irq_enable, orient_irq_source;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, debounce_count, d;
    logic [AXIS_W-1:0] accel_x, accel_y, accel_z;
    int error_cnt = 0;
    int checked = 0;
    // x, y, z, lockout trip, expected status
    logic [47:0] tbl [9] = '{48'h000_300_100_0_80, 48'h000_d00_100_0_82, 48'h300_000_100_0_84,
        48'hd00_000_100_0_86, 48'hd00_000_f00_0_87, 48'hd00_000_f00_1_c7, 48'hd00_000_f00_0_87,
        48'h600_000_f00_0_07, 48'h500_000_f00_0_85};
    always #20 ref_clk = ~ref_clk;
    orientation_status_config i_dut (.ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
        .active_mode(active_mode), .sleep_mode(sleep_mode), .accel_x(accel_x), .accel_y(accel_y),
        .accel_z(accel_z), .ztilt_trip(ztilt_trip), .debounce_count(debounce_count),
        .orient_irq_enable(orient_irq_enable), .orient_irq_source(orient_irq_source));
    orient_host host (.ref_clk(ref_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask
    // One sample pulse; axis values stay put afterwards
    task automatic smp(input logic [47:0] e);
        @(posedge ref_clk);
        #1 {accel_x, accel_y, accel_z, ztilt_trip, sample_strobe} = {e[47:12], e[8], 1'b1};
        @(posedge ref_clk);
        #1 sample_strobe = 1'b0;
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {sample_strobe, active_mode, sleep_mode, ztilt_trip, orient_irq_enable} = 5'b00001;
        {accel_x, accel_y, accel_z, debounce_count} = 44'h0;
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        rdc(8'h10, 8'h00);
        rdc(8'h11, 8'h80);
        rdc(8'h12, 8'h00);
        host.wr(8'h10, 8'hff);
        host.wr(8'h11, 8'hff);
        rdc(8'h11, 8'hc0);
        smp(tbl[1]);
        rdc(8'h10, 8'h00);
        active_mode = 1'b1;
        foreach (tbl[i]) begin
            smp(tbl[i]);
            chk({7'h00, orient_irq_source}, {7'h00, tbl[i][7]});
            rdc(8'h10, tbl[i][7:0]);
            chk({7'h00, orient_irq_source}, 8'h00);
            rdc(8'h10, tbl[i][7:0] & 8'h7f);
        end
        // Two changes with no read between them
        smp(tbl[0]);
        smp(tbl[1]);
        rdc(8'h10, 8'h82);
        host.wr(8'h11, 8'h80);
        smp(tbl[0]);
        rdc(8'h10, 8'h02);
        host.wr(8'h11, 8'h40);
        orient_irq_enable = 1'b0;
        smp(tbl[0]);
        chk({7'h00, orient_irq_source}, 8'h00);
        rdc(8'h10, 8'h80);
        // Standby and back, with a sleep change meanwhile
        {active_mode, sleep_mode} = 2'b01;
        smp(tbl[1]);
        active_mode = 1'b1;
        smp(tbl[0]);
        rdc(8'h10, 8'h80);
        debounce_count = 8'h02;
        smp(tbl[1]);
        rdc(8'h10, 8'h00);
        repeat (4) smp(tbl[1]);
        rdc(8'h10, 8'h82);
        // Decrement mode: a lapse takes one step off, so two more samples finish the count
        repeat (2) smp(tbl[0]);
        smp(tbl[1]);
        repeat (2) smp(tbl[0]);
        rdc(8'h10, 8'h80);
        // Clear mode: the same lapse restarts the count, so two samples fall short
        host.wr(8'h11, 8'hc0);
        smp(tbl[0]);
        repeat (2) smp(tbl[1]);
        smp(tbl[0]);
        repeat (2) smp(tbl[1]);
        rdc(8'h10, 8'h00);
        smp(tbl[1]);
        rdc(8'h10, 8'h82);
        // A wake/sleep change drops a full count, so the next change must count again
        sleep_mode = 1'b0;
        smp(tbl[0]);
        rdc(8'h10, 8'h02);
        final_report();
    end
endmodule
